// *** hw/cdr_mode_status.sv ***
`timescale 1ns/1ps
// Contract
// RULE1: Select low drives the test loop data and clock outputs.
// RULE2: Select high drives normal outputs and turns test outputs off.
// RULE3: Select at negative supply enables both output pairs.
// RULE4: Window flag high while oscillator within 1000 ppm of expected; code uses a window of 1/1024 (about 977 ppm).
// RULE5: Window flag low if reference missing or oscillator outside window.
// RULE6: Window flag never reports data lock; only the alarm does.
// RULE7: Error event when A equals B but transition sample T differs.
// RULE8: Alarm sets near error rate 5e-2, clears near 1e-3.
// RULE9: Alarm also set while no data signal is present.
// RULE10: Alarm depends only on error events, not data or framing.
// RULE11: Reference divider 64 for ground/negative, 128 for both negative.
// RULE12: Ethernet use needs 39.0625 or 19.53125 MHz reference outside.
// RULE13: All rate selects grounded gives division factor 1.
// RULE14: Only first rate select negative gives factor 2.
// RULE15: First and second rate selects negative give factor 4.
// RULE16: All three rate selects negative give factor 16.
// RULE17: Outside window, disable phase detector and steer oscillator back.
// RULE18: No action on A equal B; slow if T equals A, speed if B.
// RULE19: Recovered data bit is the centre sample A.
// RULE20: Errors counted over fixed bit window against two thresholds.
// RULE21: Selects are static; any change restarts frequency acquisition.
module cdr_mode_status (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic sample_a,
   input wire logic sample_t,
   input wire logic sample_b,
   input wire logic sample_strobe,
   input wire logic signal_present,
   input wire logic reference_clock_in,
   input wire logic ring_oscillator,
   input wire logic output_path_select_n,
   input wire logic output_path_select_vee,
   input wire logic ref_select_a,
   input wire logic ref_select_b,
   input wire logic rate_select_a,
   input wire logic rate_select_b,
   input wire logic rate_select_c,
   output logic recovered_data_main,
   output logic recovered_clock_main,
   output logic recovered_data_test,
   output logic recovered_clock_test,
   output logic main_out_enable,
   output logic test_out_enable,
   output logic freq_window_flag,
   output logic signal_absent_alarm,
   output logic phase_detect_enable,
   output logic phase_slow,
   output logic phase_fast,
   output logic freq_steer_up,
   output logic freq_steer_down,
   output logic [4:0] rate_div_factor,
   output logic [7:0] ref_div_factor
);
   import cdr_pkg::*;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [14:0] meta;
   logic [14:0] sync;
   logic ref_d;
   logic osc_d;
   logic strobe_d;
   // Every pin passes two flops; the first stage feeds only the second
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         meta <= 15'h0000;
         sync <= 15'h0000;
      end else begin
         meta <= {sample_a, sample_t, sample_b, sample_strobe,
                  signal_present, reference_clock_in, ring_oscillator,
                  output_path_select_n, output_path_select_vee,
                  ref_select_a, ref_select_b, rate_select_a,
                  rate_select_b, rate_select_c, 1'b0};
         sync <= meta;
      end
   end

   logic s_a, s_t, s_b, s_stb, s_sig, s_ref, s_osc, s_sel_n, s_sel_vee;
   logic [1:0] s_refsel;
   logic [2:0] s_rate;
   assign {s_a, s_t, s_b, s_stb, s_sig, s_ref, s_osc, s_sel_n,
           s_sel_vee} = sync[14:6];
   assign s_refsel = {sync[4], sync[5]};
   assign s_rate = {sync[1], sync[2], sync[3]};

   // Edge detectors read only the second stage
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ref_d <= 1'b0;
         osc_d <= 1'b0;
         strobe_d <= 1'b0;
      end else begin
         ref_d <= s_ref;
         osc_d <= s_osc;
         strobe_d <= s_stb;
      end
   end

   logic ref_edge, osc_edge, bit_edge;
   assign ref_edge = s_ref & ~ref_d;
   assign osc_edge = s_osc & ~osc_d;
   assign bit_edge = s_stb & ~strobe_d;

   // ------------------------------------------------------------
   // Static straps and divider factors
   // ------------------------------------------------------------
   logic [4:0] straps_q;
   logic strap_change;
   assign strap_change = ({s_refsel, s_rate} != straps_q);
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         straps_q <= 5'h00;
         rate_div_factor <= RATE_DIV_1;
         ref_div_factor <= REF_DIV_64;
      end else begin
         straps_q <= {s_refsel, s_rate};
         rate_div_factor <= rate_factor(s_rate); // RULE13 RULE14 RULE15 RULE16
         ref_div_factor <= ref_factor(s_refsel); // RULE11
      end
   end

   // ------------------------------------------------------------
   // Frequency window detector
   // ------------------------------------------------------------
   cdr_fw_t fw_state;
   logic [10:0] gate_cnt;
   logic [18:0] osc_cnt;
   logic [11:0] ref_idle;
   logic [18:0] expect_cnt;
   logic [18:0] tol;
   logic gate_done, in_win, ref_lost;
   // The gate ends on a reference edge, so a dead reference never closes it
   assign expect_cnt = 19'({ref_div_factor, 10'h000});
   assign tol = expect_cnt >> TOL_SHIFT;
   assign gate_done = ref_edge && (gate_cnt == REF_GATE - 11'h001);
   assign in_win = (osc_cnt + 19'(osc_edge) >= expect_cnt - tol) &&
                   (osc_cnt + 19'(osc_edge) <= expect_cnt + tol);
   assign ref_lost = (ref_idle >= 12'(REF_LOSS_CYC));

   // Watchdog on the reference clock
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ref_idle <= 12'h000;
      end else if (ref_edge) begin
         ref_idle <= 12'h000;
      end else if (ref_idle != LOSS_CNT_MAX) begin
         ref_idle <= ref_idle + 12'h001;
      end
   end

   // Gate counters; a strap change throws the measurement away
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gate_cnt <= 11'h000;
         osc_cnt <= 19'h00000;
      end else if (strap_change || gate_done || ref_lost) begin // RULE21
         gate_cnt <= 11'h000;
         osc_cnt <= 19'h00000;
      end else begin
         gate_cnt <= gate_cnt + 11'(ref_edge);
         osc_cnt <= osc_cnt + 19'(osc_edge);
      end
   end

   // Window state, flag and steering
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fw_state <= FW_OUT;
         freq_window_flag <= 1'b0;
         freq_steer_up <= 1'b0;
         freq_steer_down <= 1'b0;
      end else if (strap_change || ref_lost) begin // RULE5 RULE21
         fw_state <= FW_OUT;
         freq_window_flag <= 1'b0;
         freq_steer_up <= 1'b0;
         freq_steer_down <= 1'b0;
      end else if (gate_done) begin
         fw_state <= in_win ? FW_IN : FW_OUT; // RULE4 RULE5
         freq_window_flag <= in_win; // RULE6
         freq_steer_up <= !in_win && (osc_cnt < expect_cnt); // RULE17
         freq_steer_down <= !in_win && (osc_cnt >= expect_cnt);
      end
   end

   // ------------------------------------------------------------
   // Phase detector and data path
   // ------------------------------------------------------------
   // Steps only while inside the window; the frequency steering owns the rest
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         phase_detect_enable <= 1'b0;
         phase_slow <= 1'b0;
         phase_fast <= 1'b0;
      end else begin
         phase_detect_enable <= (fw_state == FW_IN); // RULE17
         phase_slow <= bit_edge && fw_state == FW_IN &&
                       s_a != s_b && s_t == s_a; // RULE18
         phase_fast <= bit_edge && fw_state == FW_IN &&
                       s_a != s_b && s_t == s_b; // RULE18
      end
   end

   // Output mux; the supply-level select overrides the TTL level
   logic en_main, en_test;
   assign en_main = s_sel_vee | s_sel_n; // RULE2 RULE3
   assign en_test = s_sel_vee | ~s_sel_n; // RULE1 RULE3
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         main_out_enable <= 1'b0;
         test_out_enable <= 1'b0;
         recovered_data_main <= 1'b0;
         recovered_clock_main <= 1'b0;
         recovered_data_test <= 1'b0;
         recovered_clock_test <= 1'b0;
      end else begin
         main_out_enable <= en_main;
         test_out_enable <= en_test;
         // Disabled clocks are parked low at once and disabled data at the next strobe edge, to save switching power
         if (bit_edge) begin
            recovered_data_main <= en_main & s_a; // RULE19
            recovered_data_test <= en_test & s_a; // RULE19
         end
         recovered_clock_main <= en_main & s_stb;
         recovered_clock_test <= en_test & s_stb;
      end
   end

   // ------------------------------------------------------------
   // Error-rate based signal loss
   // ------------------------------------------------------------
   logic [10:0] bit_cnt;
   logic [10:0] err_cnt;
   logic [11:0] data_idle;
   logic err_event, win_done, no_data;
   assign err_event = bit_edge && s_a == s_b && s_t != s_a; // RULE7 RULE10
   assign win_done = bit_edge && (bit_cnt == BER_WIN - 11'h001); // RULE20
   assign no_data = !s_sig || (data_idle >= 12'(DATA_LOSS_CYC));

   // Fixed window of bit periods; bit and error counts clear together at its end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt <= 11'h000;
         err_cnt <= 11'h000;
      end else if (win_done) begin
         bit_cnt <= 11'h000;
         err_cnt <= 11'h000;
      end else begin
         bit_cnt <= bit_cnt + 11'(bit_edge);
         err_cnt <= err_cnt + 11'(err_event); // RULE20
      end
   end

   // Strobe watchdog catches a silent line even if the present pin lies
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         data_idle <= 12'h000;
      end else if (bit_edge) begin
         data_idle <= 12'h000;
      end else if (data_idle != LOSS_CNT_MAX) begin
         data_idle <= data_idle + 12'h001;
      end
   end

   // Alarm starts raised until a window with at most BER_CLR errors proves the data
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         signal_absent_alarm <= 1'b1;
      end else if (no_data) begin
         signal_absent_alarm <= 1'b1; // RULE9
      end else if (win_done) begin
         if (err_cnt + 11'(err_event) >= BER_SET) begin
            signal_absent_alarm <= 1'b1; // RULE8
         end else if (err_cnt + 11'(err_event) <= BER_CLR) begin
            signal_absent_alarm <= 1'b0; // RULE8
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_sel_low;
      !s_sel_n && !s_sel_vee;
   endsequence
   sequence s_sel_high;
      s_sel_n && !s_sel_vee;
   endsequence

   a_test_path_on: assert property (s_sel_low |=> test_out_enable) // RULE1
      else $error("test outputs not enabled for low select");
   a_main_path_only: assert property (s_sel_high |=>
      main_out_enable && !test_out_enable) // RULE2
      else $error("wrong outputs for high select");
   a_both_paths: assert property (s_sel_vee |=>
      main_out_enable && test_out_enable) // RULE3
      else $error("supply select did not enable both pairs");
   a_window_entry: assert property (gate_done && in_win && !ref_lost &&
      !strap_change |=> freq_window_flag) // RULE4
      else $error("flag not raised inside window");
   a_ref_loss_flag: assert property (ref_lost |=> !freq_window_flag) // RULE5
      else $error("flag high with reference missing");
   a_error_count: assert property (err_event && !win_done |=>
      err_cnt == $past(err_cnt) + 11'h001) // RULE7
      else $error("error event not counted");
   a_alarm_high_rate: assert property (!no_data && win_done &&
      err_cnt >= BER_SET |=> signal_absent_alarm) // RULE8
      else $error("alarm missed high error rate");
   a_alarm_no_data: assert property (!s_sig |=> signal_absent_alarm) // RULE9
      else $error("alarm low with no data");
   a_pd_gated: assert property (!phase_detect_enable |->
      !phase_slow && !phase_fast ##1 1) // RULE17
      else $error("phase step while detector disabled");
   a_strap_restart: assert property (strap_change |=>
      !freq_window_flag ##1 !freq_window_flag) // RULE21
      else $error("strap change did not restart acquisition");
endmodule

// *** hw/cdr_pkg.sv ***
package cdr_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int REF_LOSS_NS = 2000;
   localparam int REF_LOSS_CYC = (REF_LOSS_NS * CLK_MHZ) / 1000;
   localparam int DATA_LOSS_NS = 4000;
   localparam int DATA_LOSS_CYC = (DATA_LOSS_NS * CLK_MHZ) / 1000;
   localparam logic [11:0] LOSS_CNT_MAX = 12'hFFF;

   // ------------------------------------------------------------
   // Frequency window and error rate
   // ------------------------------------------------------------
   localparam logic [10:0] REF_GATE = 11'h400;
   localparam int TOL_SHIFT = 10;
   localparam logic [10:0] BER_WIN = 11'h400;
   localparam logic [10:0] BER_SET = 11'h033;
   localparam logic [10:0] BER_CLR = 11'h001;

   // ------------------------------------------------------------
   // Divider factors
   // ------------------------------------------------------------
   localparam logic [4:0] RATE_DIV_1 = 5'h01;
   localparam logic [4:0] RATE_DIV_2 = 5'h02;
   localparam logic [4:0] RATE_DIV_4 = 5'h04;
   localparam logic [4:0] RATE_DIV_16 = 5'h10;
   localparam logic [7:0] REF_DIV_64 = 8'h40;
   localparam logic [7:0] REF_DIV_128 = 8'h80;

   typedef enum logic [1:0] {
      FW_OUT = 2'b00,
      FW_IN = 2'b01
   } cdr_fw_t;

   // Selects: bit set means strapped to the negative supply
   function automatic logic [4:0] rate_factor(input logic [2:0] cba);
      unique case (cba)
         3'b000: rate_factor = RATE_DIV_1;
         3'b001: rate_factor = RATE_DIV_2;
         3'b011: rate_factor = RATE_DIV_4;
         3'b111: rate_factor = RATE_DIV_16;
         default: rate_factor = RATE_DIV_1;
      endcase
   endfunction

   function automatic logic [7:0] ref_factor(input logic [1:0] ba);
      ref_factor = (ba == 2'b11) ? REF_DIV_128 : REF_DIV_64;
   endfunction
endpackage

// *** testbench/cdr_front_end.sv ***
`timescale 1ns/1ps
// Front end model: sends one window of 1024 bits for each go request
module cdr_front_end (
   input wire logic sys_clk,
   input wire logic go,
   input wire logic [10:0] n_err,
   input wire logic [31:0] rnd,
   output logic sample_a,
   output logic sample_t,
   output logic sample_b,
   output logic sample_strobe,
   output logic done,
   output logic last_a
);
   int i;
   // Samples invert after the strobe falls so stale levels never pass
   initial begin
      {sample_a, sample_t, sample_b, sample_strobe, done, last_a} = 6'h00;
      forever begin
         @(negedge sys_clk);
         if (go && !done) begin
            for (i = 0; i < 1024; i++) begin
               sample_a = rnd[0];
               sample_b = (i < n_err) ? rnd[0] : rnd[1];
               if (i < n_err)
                  sample_t = ~rnd[0];
               else if (sample_a == sample_b)
                  sample_t = sample_a;
               else
                  sample_t = rnd[2] ? sample_a : sample_b;
               last_a = sample_a;
               sample_strobe = 1'b1;
               repeat (3) @(negedge sys_clk);
               sample_strobe = 1'b0;
               {sample_a, sample_t, sample_b} = ~{sample_a, sample_t, sample_b};
               repeat (3) @(negedge sys_clk);
            end
            done = 1'b1;
         end else if (!go) begin
            done = 1'b0;
         end
      end
   end
endmodule

// *** testbench/cdr_mode_status_tb_top.sv ***
`timescale 1ns/1ps
module cdr_mode_status_tb_top;
   import cdr_pkg::*;
   logic sys_clk, rstn, signal_present, reference_clock_in, ring_oscillator;
   logic output_path_select_n, output_path_select_vee, go, done, last_a;
   logic ref_select_a, ref_select_b, rate_select_a, rate_select_b;
   logic rate_select_c, sample_a, sample_t, sample_b, sample_strobe;
   logic recovered_data_main, recovered_clock_main, recovered_data_test;
   logic recovered_clock_test, main_out_enable, test_out_enable;
   logic freq_window_flag, signal_absent_alarm, phase_detect_enable;
   logic phase_slow, phase_fast, freq_steer_up, freq_steer_down, alarm_exp;
   logic [4:0] rate_div_factor;
   logic [7:0] ref_div_factor;
   logic [10:0] n_err;
   logic [31:0] rnd;
   logic ref_run;
   logic [1:0] sel_tab[3] = '{2'b00, 2'b01, 2'b10};
   logic [1:0] en_tab[3] = '{2'b01, 2'b10, 2'b11};
   logic [2:0] rate_tab[5] = '{3'b000, 3'b001, 3'b011, 3'b111, 3'b010};
   logic [4:0] rexp[5] = '{RATE_DIV_1, RATE_DIV_2, RATE_DIV_4, RATE_DIV_16,
                           RATE_DIV_1};
   logic [1:0] ref_tab[3] = '{2'b10, 2'b11, 2'b00};
   logic [7:0] fexp[3] = '{REF_DIV_64, REF_DIV_128, REF_DIV_64};
   int errors, n_compared, cycles, pulses, i;

   cdr_mode_status dut (.sys_clk, .rstn, .sample_a, .sample_t, .sample_b,
      .sample_strobe, .signal_present, .reference_clock_in, .ring_oscillator,
      .output_path_select_n, .output_path_select_vee, .ref_select_a,
      .ref_select_b, .rate_select_a, .rate_select_b, .rate_select_c,
      .recovered_data_main, .recovered_clock_main, .recovered_data_test,
      .recovered_clock_test, .main_out_enable, .test_out_enable,
      .freq_window_flag, .signal_absent_alarm, .phase_detect_enable,
      .phase_slow, .phase_fast, .freq_steer_up, .freq_steer_down,
      .rate_div_factor, .ref_div_factor);

   cdr_front_end front (.sys_clk, .go, .n_err, .rnd, .sample_a, .sample_t,
      .sample_b, .sample_strobe, .done, .last_a);

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xorshift = x ^ (x << 5);
   endfunction

   // Hysteresis: only the two thresholds move the alarm
   function automatic logic next_alarm(input logic cur, input int nerr);
      next_alarm = (nerr >= 51) ? 1'b1 : ((nerr <= 1) ? 1'b0 : cur);
   endfunction

   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One window with a fixed count of error bits at its start; the pair
   // enables are worked out from the select pins that the bench drives
   task automatic run_window(input int nerr);
      int k;
      logic m_exp, t_exp;
      k = 0;
      // A stale done from the last window must clear before a new go
      while (done !== 1'b0 && k < 8) begin
         @(negedge sys_clk);
         k++;
      end
      n_err = nerr[10:0];
      go = 1'b1;
      m_exp = output_path_select_vee | output_path_select_n;
      t_exp = output_path_select_vee | ~output_path_select_n;
      while (sample_strobe !== 1'b1 && k < 16) begin
         @(negedge sys_clk);
         k++;
      end
      // The synced strobe stands on the clock outputs for three cycles
      repeat (3) @(negedge sys_clk);
      check("clk_main", {7'h00, recovered_clock_main},
            {7'h00, m_exp});
      check("clk_test", {7'h00, recovered_clock_test},
            {7'h00, t_exp});
      k = 0;
      while (done !== 1'b1 && k < 8000) begin
         @(negedge sys_clk);
         k++;
      end
      check("done", {7'h00, done}, 8'h01);
      go = 1'b0;
      @(negedge sys_clk);
      alarm_exp = next_alarm(alarm_exp, nerr);
      check("alarm", {7'h00, signal_absent_alarm}, {7'h00, alarm_exp});
      check("data", {7'h00, recovered_data_main},
            {7'h00, last_a & m_exp});
      check("data_test", {7'h00, recovered_data_test},
            {7'h00, last_a & t_exp});
   endtask

   // Clock, divided oscillator tick and random source
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   always @(negedge sys_clk) ring_oscillator <= ~ring_oscillator;
   always @(negedge sys_clk) rnd <= xorshift(rnd);

   // Reference source at 19.53125 MHz; every fifth edge lands on a falling clock edge, never on a rising one
   initial begin
      forever begin
         #25.6;
         if (ref_run)
            reference_clock_in = ~reference_clock_in;
      end
   end

   // Phase pulses must stay quiet: the slow tick never reaches the window
   always @(posedge sys_clk) begin
      cycles++;
      if (rstn && (phase_slow === 1'b1 || phase_fast === 1'b1 ||
                   phase_detect_enable === 1'b1))
         pulses++;
      if (cycles == 60000) begin
         errors++;
         finish_test();
      end
   end

   initial begin
      {rstn, reference_clock_in, ring_oscillator, go} = 4'h0;
      {output_path_select_n, output_path_select_vee} = 2'h0;
      {ref_select_a, ref_select_b, rate_select_a} = 3'h0;
      {rate_select_b, rate_select_c} = 2'h0;
      signal_present = 1'b1;
      n_err = 11'h000;
      rnd = 32'h66291A86;
      errors = 0;
      n_compared = 0;
      cycles = 0;
      pulses = 0;
      ref_run = 1'b0;
      alarm_exp = 1'b1;
      repeat (5) @(negedge sys_clk);
      rstn = 1'b1;
      @(posedge sys_clk);
      #1;
      check("alarm_rst", {7'h00, signal_absent_alarm}, 8'h01);
      check("div_rst", {3'h0, rate_div_factor}, 8'h01);
      for (i = 0; i < 3; i++) begin
         @(negedge sys_clk);
         {output_path_select_vee, output_path_select_n} = sel_tab[i];
         repeat (4) @(negedge sys_clk);
         check("out_en", {6'h00, main_out_enable, test_out_enable},
               {6'h00, en_tab[i]});
         if (!en_tab[i][0])
            check("test_off", {6'h00, recovered_data_test,
                  recovered_clock_test}, 8'h00);
      end
      {output_path_select_vee, output_path_select_n} = 2'b01;
      for (i = 0; i < 5; i++) begin
         {rate_select_c, rate_select_b, rate_select_a} = rate_tab[i];
         if (i < 3)
            {ref_select_b, ref_select_a} = ref_tab[i];
         repeat (4) @(negedge sys_clk);
         check("rate", {3'h0, rate_div_factor}, {3'h0, rexp[i]});
         if (i < 3)
            check("ref", ref_div_factor, fexp[i]);
      end
      repeat (300) @(negedge sys_clk);
      check("flag_noref", {7'h00, freq_window_flag}, 8'h00);
      check("pd_off", {7'h00, phase_detect_enable}, 8'h00);
      check("steer_off", {6'h00, freq_steer_up, freq_steer_down},
            8'h00);
      {ref_select_b, ref_select_a} = 2'b11;
      ref_run = 1'b1;
      // One gate of reference edges takes about 6560 cycles; the tick
      // gives far fewer than 128 edges a period, so steer up
      repeat (7000) @(negedge sys_clk);
      check("steer", {6'h00, freq_steer_up, freq_steer_down},
            8'h02);
      check("flag_slow", {7'h00, freq_window_flag}, 8'h00);
      ref_run = 1'b0;
      run_window(0);
      run_window(2);
      run_window(51);
      run_window(50);
      {output_path_select_vee, output_path_select_n} = 2'b10;
      run_window(1);
      check("flag_data", {7'h00, freq_window_flag}, 8'h00);
      signal_present = 1'b0;
      repeat (5) @(negedge sys_clk);
      check("alarm_nosig", {7'h00, signal_absent_alarm}, 8'h01);
      signal_present = 1'b1;
      alarm_exp = 1'b1;
      {output_path_select_vee, output_path_select_n} = 2'b00;
      run_window(0);
      repeat (480) @(negedge sys_clk);
      check("alarm_idle", {7'h00, signal_absent_alarm}, 8'h00);
      repeat (30) @(negedge sys_clk);
      check("alarm_lost", {7'h00, signal_absent_alarm}, 8'h01);
      check("pulses", (pulses > 255) ? 8'hFF : pulses[7:0],
            8'h00);
      finish_test();
   end
endmodule
